// >>> core/srsf_flag.sv
// Purpose: one clear-only status flag with read-of-one arming
// Assumes: reads and writes come from the register port on the same clock
// Notes:   hardware set wins over any clear in the same cycle
`timescale 1ns/10ps
module srsf_flag (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic set_in,
  input  wire logic rd_in,
  input  wire logic wr_zero_in,
  input  wire logic hw_clr_in,
  output logic      flag_out
);
  logic armed_reg;
  logic armed_next;
  logic flag_next;
  // arm on a read that sees 1; a write of 0 clears only when armed
  assign flag_next  = set_in ? 1'b1 : ((wr_zero_in && armed_reg) || hw_clr_in) ? 1'b0 : flag_out;
  assign armed_next = set_in ? 1'b0 : (rd_in && flag_out) ? 1'b1
                    : (wr_zero_in || !flag_out) ? 1'b0 : armed_reg;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_out  <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      flag_out  <= flag_next;
      armed_reg <= armed_next;
    end
  end
endmodule : srsf_flag

// >>> core/srsf_sync.sv
// Purpose: two flip-flop synchroniser for pin-level inputs
// Assumes: asynchronous active-low reset
// Notes:   first stage read only by second stage
`timescale 1ns/10ps
module srsf_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule : srsf_sync

// >>> core/srsf_top.sv
// Purpose: receive-full and overrun status flags of a serial interface
// Assumes: receiver core delivers a completion toggle with word and errors
// Notes:   line-side event inputs arrive from another domain and are synchronised
// How it works
// - a clean completion moves the shift word into the data register and sets receive-full
// - receive-full clears on a 0 write only after software has read it as 1
// - a dma read of the data register driven by the receive request clears receive-full
// - clearing the receive enable leaves receive-full untouched
// - a completion while receive-full is 1 is an overrun and the new word is dropped
// - overrun flag bit 5 sets on a completion while receive-full is 1
// - on overrun the data register keeps the earlier word
// - while the overrun flag is 1 no further reception is accepted
// - in clocked synchronous mode an overrun also halts transmission
// - overrun flag clears only on a 0 write after a read of 1
// - clearing the receive enable leaves the overrun flag untouched
// - an async framing or parity error moves the word but does not set receive-full
`timescale 1ns/10ps
module srsf_top
  import srsf_pkg::*;
#(
  parameter int DW = 8
) (
  input  wire logic          core_clk_in,
  input  wire logic          rst_n_in,
  input  wire logic [3:0]    addr_in,
  input  wire logic [7:0]    wdata_in,
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  output logic      [7:0]    rdata_out,
  input  wire logic          rx_done_tgl_in,
  input  wire logic [DW-1:0] rx_shift_in,
  input  wire logic          rx_frame_err_in,
  input  wire logic          rx_parity_err_in,
  input  wire logic          dma_ack_in,
  output logic               rx_data_request_out,
  output logic               rx_hold_out,
  output logic               tx_hold_out,
  output logic               irq_out
);
  // line-side inputs: toggle per completion, word and errors held stable across it
  logic          done_sync;
  logic          done_prev_reg;
  logic [DW-1:0] shift_sync;
  logic          ferr_sync;
  logic          perr_sync;
  srsf_sync #(.W(1)) u_sync_done (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .d_in        (rx_done_tgl_in),
    .q_out       (done_sync)
  );
  srsf_sync #(.W(DW + 2)) u_sync_data (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .d_in        ({rx_frame_err_in, rx_parity_err_in, rx_shift_in}),
    .q_out       ({ferr_sync, perr_sync, shift_sync})
  );

  logic [7:0]    control_reg;
  logic [DW-1:0] rx_data_reg;
  logic [SRSF_IRQ_W-1:0] irq_st_reg;
  logic [SRSF_IRQ_W-1:0] irq_en_reg;
  logic          rx_full_flag;
  logic          overrun_error_flag;
  logic          framing_error_flag;
  logic          parity_error_flag;

  wire rx_enable_bit = control_reg[SRSF_CTL_RX_EN];
  wire sync_mode     = control_reg[SRSF_CTL_SYNC];
  wire dma_mode      = control_reg[SRSF_CTL_DMA];

  wire rx_done       = done_sync ^ done_prev_reg;
  wire any_err       = overrun_error_flag || framing_error_flag || parity_error_flag;
  wire rx_accept     = rx_done && rx_enable_bit && !any_err;
  wire async_err     = !sync_mode && (ferr_sync || perr_sync);
  wire is_overrun    = rx_accept && rx_full_flag;
  wire clean_done    = rx_accept && !rx_full_flag && !async_err;
  wire err_done      = rx_accept && !rx_full_flag && async_err;
  wire load_data     = clean_done || err_done;

  wire sel_status    = addr_in == SRSF_OFS_STATUS;
  wire sel_control   = addr_in == SRSF_OFS_CONTROL;
  wire sel_rxdata    = addr_in == SRSF_OFS_RXDATA;
  wire sel_irq_st    = addr_in == SRSF_OFS_IRQ_ST;
  wire sel_irq_en    = addr_in == SRSF_OFS_IRQ_EN;
  wire sel_irq_clr   = addr_in == SRSF_OFS_IRQ_CLR;
  wire st_rd         = rd_in && sel_status;
  wire st_wr         = wr_in && sel_status;
  wire dma_clr       = dma_mode && rx_data_request_out && dma_ack_in;

  wire [7:0] status_view = {1'b0, rx_full_flag, overrun_error_flag,
                            framing_error_flag, parity_error_flag, 3'h0};
  wire [7:0] rdata_next  = !rd_in      ? 8'h00 :
                           sel_status  ? status_view :
                           sel_control ? control_reg :
                           sel_rxdata  ? 8'(rx_data_reg) :
                           sel_irq_st  ? 8'(irq_st_reg) :
                           sel_irq_en  ? 8'(irq_en_reg) : 8'h00;

  // receive enable does not reach any flag clear path
  srsf_flag u_full (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (clean_done),
    .rd_in       (st_rd),
    .wr_zero_in  (st_wr && !wdata_in[SRSF_BIT_RX_FULL]),
    .hw_clr_in   (dma_clr),
    .flag_out    (rx_full_flag)
  );
  srsf_flag u_overrun (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (is_overrun),
    .rd_in       (st_rd),
    .wr_zero_in  (st_wr && !wdata_in[SRSF_BIT_OVERRUN]),
    .hw_clr_in   (1'b0),
    .flag_out    (overrun_error_flag)
  );
  srsf_flag u_framing (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (err_done && ferr_sync),
    .rd_in       (st_rd),
    .wr_zero_in  (st_wr && !wdata_in[SRSF_BIT_FRAMING]),
    .hw_clr_in   (1'b0),
    .flag_out    (framing_error_flag)
  );
  srsf_flag u_parity (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (err_done && perr_sync),
    .rd_in       (st_rd),
    .wr_zero_in  (st_wr && !wdata_in[SRSF_BIT_PARITY]),
    .hw_clr_in   (1'b0),
    .flag_out    (parity_error_flag)
  );

  wire [SRSF_IRQ_W-1:0] irq_set  = {err_done, is_overrun, clean_done};
  wire [SRSF_IRQ_W-1:0] irq_clr  = (wr_in && sel_irq_clr) ? wdata_in[SRSF_IRQ_W-1:0] : '0;
  wire [SRSF_IRQ_W-1:0] irq_st_next = irq_set | (irq_st_reg & ~irq_clr);
  wire rx_req_next = rx_full_flag && !dma_clr && control_reg[SRSF_CTL_RX_IE];
  wire tx_hold_next = sync_mode && (overrun_error_flag || is_overrun);
  wire rx_hold_next = any_err || is_overrun || err_done;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_prev_reg <= 1'b0;
      control_reg   <= SRSF_RST_CONTROL;
      rx_data_reg   <= DW'(SRSF_RST_DATA);
      irq_en_reg    <= '0;
    end else begin
      done_prev_reg <= done_sync;
      if (wr_in && sel_control) begin
        control_reg <= wdata_in;
      end
      if (wr_in && sel_irq_en) begin
        irq_en_reg <= wdata_in[SRSF_IRQ_W-1:0];
      end
      if (load_data) begin
        rx_data_reg <= shift_sync;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_st_reg          <= '0;
      rdata_out           <= 8'h00;
      rx_data_request_out <= 1'b0;
      rx_hold_out         <= 1'b0;
      tx_hold_out         <= 1'b0;
      irq_out             <= 1'b0;
    end else begin
      irq_st_reg          <= irq_st_next;
      rdata_out           <= rdata_next;
      rx_data_request_out <= rx_req_next;
      rx_hold_out         <= rx_hold_next;
      tx_hold_out         <= tx_hold_next;
      irq_out             <= |(irq_st_next & irq_en_reg);
    end
  end
endmodule : srsf_top

// >>> include/srsf_pkg.sv
// Purpose: shared constants for the serial receive status flag block
// Assumes: 8-bit register port, one clock
// Notes:   offsets are word indexes on the plain register port
package srsf_pkg;
  localparam logic [3:0] SRSF_OFS_STATUS  = 4'h0;
  localparam logic [3:0] SRSF_OFS_CONTROL = 4'h1;
  localparam logic [3:0] SRSF_OFS_RXDATA  = 4'h2;
  localparam logic [3:0] SRSF_OFS_IRQ_ST  = 4'h3;
  localparam logic [3:0] SRSF_OFS_IRQ_EN  = 4'h4;
  localparam logic [3:0] SRSF_OFS_IRQ_CLR = 4'h5;
  localparam int SRSF_BIT_RX_FULL  = 6;
  localparam int SRSF_BIT_OVERRUN  = 5;
  localparam int SRSF_BIT_FRAMING  = 4;
  localparam int SRSF_BIT_PARITY   = 3;
  localparam int SRSF_CTL_RX_EN    = 0;
  localparam int SRSF_CTL_RX_IE    = 1;
  localparam int SRSF_CTL_SYNC     = 2;
  localparam int SRSF_CTL_DMA      = 3;
  localparam int SRSF_IRQ_RX_FULL  = 0;
  localparam int SRSF_IRQ_OVERRUN  = 1;
  localparam int SRSF_IRQ_ERROR    = 2;
  localparam int SRSF_IRQ_W        = 3;
  localparam logic [7:0] SRSF_RST_STATUS  = 8'h00;
  localparam logic [7:0] SRSF_RST_CONTROL = 8'h00;
  localparam logic [7:0] SRSF_RST_DATA    = 8'h00;
endpackage : srsf_pkg

// >>> tb/srsf_assertions.sv
// Purpose: port-level checks of the receive status flag block
// Assumes: request registered one edge after receive-full; hold outputs rise on the same edge as their flags
// Notes:   history bits cover the write or dma cause of a fall
`timescale 1ns/10ps
module srsf_assertions (
  input wire logic       core_clk_in,
  input wire logic       rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic       dma_ack_in,
  input wire logic [7:0] rdata_out,
  input wire logic       rx_data_request_out,
  input wire logic       rx_hold_out,
  input wire logic       tx_hold_out
);
  logic [3:0] wr_hist_reg;
  logic [3:0] dma_hist_reg;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_hist_reg  <= 4'h0;
      dma_hist_reg <= 4'h0;
    end else begin
      wr_hist_reg  <= {wr_hist_reg[2:0], wr_in};
      dma_hist_reg <= {dma_hist_reg[2:0], dma_ack_in};
    end
  end
  chk_rdata_idle: assert property (
    !$past(rd_in) |-> rdata_out == 8'h00) else $error("rdata");
  chk_rdata_unmapped: assert property (
    $past(rd_in) && $past(addr_in) > 4'h5 |-> rdata_out == 8'h00)
    else $error("unmapped read");
  chk_req_fall_cause: assert property (
    $fell(rx_data_request_out) |-> |{wr_hist_reg, dma_hist_reg})
    else $error("request fell alone");
  chk_hold_fall_cause: assert property ($fell(rx_hold_out) |-> |wr_hist_reg)
    else $error("hold fell alone");
  chk_tx_fall_cause: assert property (
    $fell(tx_hold_out) |-> |wr_hist_reg) else $error("tx fell");
  chk_tx_needs_rx: assert property (
    tx_hold_out |-> rx_hold_out) else $error("tx without rx");
  chk_hold_no_rx: assert property (rx_hold_out && $past(rx_hold_out) && !(|wr_hist_reg)
    |-> !$rose(rx_data_request_out)) else $error("rx while held");
  chk_tx_rise_cause: assert property (
    $rose(tx_hold_out) |-> !$past(rx_hold_out) || |wr_hist_reg)
    else $error("tx rose alone");
endmodule : srsf_assertions
bind srsf_top srsf_assertions i_chk (.core_clk_in, .rst_n_in, .addr_in, .wr_in, .rd_in,
  .dma_ack_in, .rdata_out, .rx_data_request_out, .rx_hold_out, .tx_hold_out);

// >>> tb/srsf_line_model.sv
// Purpose: remote transmitter handing completed words to the block
// Assumes: one send pulse per word, sends spaced apart
// Notes:   word and errors turn to their inverse once held long enough
`timescale 1ns/10ps
module srsf_line_model (
  input  wire logic       core_clk_in,
  input  wire logic       send_in,
  input  wire logic [7:0] word_in,
  input  wire logic       fe_in,
  input  wire logic       pe_in,
  output logic            tgl_out,
  output logic [7:0]      shift_out,
  output logic            fe_out,
  output logic            pe_out
);
  logic [3:0] age_reg;
  initial {tgl_out, shift_out, fe_out, pe_out, age_reg} = 15'h0000;
  always @(posedge core_clk_in) begin
    if (send_in) {shift_out, fe_out, pe_out, age_reg} <= {word_in, fe_in, pe_in, 4'h1};
    else if (age_reg != 4'h0) age_reg <= age_reg + 4'h1;
    if (age_reg == 4'h1) tgl_out <= ~tgl_out;
    if (age_reg == 4'h8) {shift_out, fe_out, pe_out, age_reg} <= {~shift_out, ~fe_out, ~pe_out, 4'h0};
  end
endmodule : srsf_line_model

// >>> tb/srsf_top_tb.sv
// Purpose: self-checking bench of the receive status flag block
// Assumes: line model feeds completed words
// Notes:   reads are queued and compared by a monitor
`timescale 1ns/10ps
module srsf_top_tb;
  import srsf_pkg::*;
  logic       core_clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, rd_d = 1'b0;
  logic       dma_ack_in = 1'b0, send_go = 1'b0, send_fe = 1'b0, send_pe = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00, send_word = 8'h00, w1, w2, rdata_out, rx_shift_in;
  logic       rx_done_tgl_in, rx_frame_err_in, rx_parity_err_in;
  logic       rx_data_request_out, rx_hold_out, tx_hold_out, irq_out;
  logic [7:0] exp_q[$];
  int         bad_count = 0, n_tests = 0;
  always #10 core_clk_in = ~core_clk_in;
  srsf_top i_dut (.core_clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .rx_done_tgl_in, .rx_shift_in, .rx_frame_err_in, .rx_parity_err_in, .dma_ack_in,
    .rx_data_request_out, .rx_hold_out, .tx_hold_out, .irq_out);
  srsf_line_model i_line (.core_clk_in, .send_in(send_go), .word_in(send_word),
    .fe_in(send_fe), .pe_in(send_pe), .tgl_out(rx_done_tgl_in), .shift_out(rx_shift_in),
    .fe_out(rx_frame_err_in), .pe_out(rx_parity_err_in));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in) {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
    @(posedge core_clk_in) wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge core_clk_in) {addr_in, rd_in} <= {a, 1'b1};
    @(posedge core_clk_in) rd_in <= 1'b0;
  endtask : rd
  task automatic send(input logic [7:0] w, input logic f, input logic p);
    @(posedge core_clk_in) {send_word, send_fe, send_pe, send_go} <= {w, f, p, 1'b1};
    @(posedge core_clk_in) send_go <= 1'b0;
    repeat (12) @(posedge core_clk_in);
  endtask : send
  task automatic lvl(input logic [3:0] e);
    repeat (3) @(posedge core_clk_in);
    #1 chk("req hold tx irq", {4'h0, e},
      {4'h0, rx_data_request_out, rx_hold_out, tx_hold_out, irq_out});
  endtask : lvl
  task automatic finish_test;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  always @(posedge core_clk_in) rd_d <= rd_in;
  always @(negedge core_clk_in) if (rd_d) chk("rdata", exp_q.pop_front(), rdata_out);
  initial begin
    repeat (20000) @(posedge core_clk_in);
    bad_count++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h2795e893));
    w1 = $urandom;
    w2 = $urandom;
    repeat (10) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(SRSF_OFS_STATUS, SRSF_RST_STATUS);
    rd(SRSF_OFS_CONTROL, SRSF_RST_CONTROL);
    rd(4'hf, 8'h00);
    wr(SRSF_OFS_CONTROL, 8'h03);
    wr(SRSF_OFS_IRQ_EN, 8'h07);
    send(w1, 1'b0, 1'b0);
    lvl(4'h9);
    wr(SRSF_OFS_STATUS, 8'h00);
    rd(SRSF_OFS_STATUS, 8'h40);
    rd(SRSF_OFS_RXDATA, w1);
    wr(SRSF_OFS_STATUS, 8'h00);
    rd(SRSF_OFS_STATUS, 8'h00);
    send(w1, 1'b0, 1'b0);
    send(w2, 1'b0, 1'b0);
    rd(SRSF_OFS_STATUS, 8'h60);
    rd(SRSF_OFS_RXDATA, w1);
    lvl(4'hd);
    wr(SRSF_OFS_CONTROL, 8'h02);
    rd(SRSF_OFS_STATUS, 8'h60);
    wr(SRSF_OFS_CONTROL, 8'h03);
    wr(SRSF_OFS_STATUS, 8'h20);
    send(~w1, 1'b0, 1'b0);
    rd(SRSF_OFS_RXDATA, w1);
    rd(SRSF_OFS_STATUS, 8'h20);
    wr(SRSF_OFS_CONTROL, 8'h07);
    lvl(4'h7);
    wr(SRSF_OFS_STATUS, 8'h00);
    rd(SRSF_OFS_STATUS, 8'h00);
    lvl(4'h1);
    wr(SRSF_OFS_CONTROL, 8'h0b);
    send(w2, 1'b0, 1'b0);
    @(posedge core_clk_in) dma_ack_in <= 1'b1;
    @(posedge core_clk_in) dma_ack_in <= 1'b0;
    rd(SRSF_OFS_STATUS, 8'h00);
    wr(SRSF_OFS_CONTROL, 8'h03);
    send(w1, 1'b1, 1'b0);
    rd(SRSF_OFS_STATUS, 8'h10);
    rd(SRSF_OFS_RXDATA, w1);
    lvl(4'h5);
    wr(SRSF_OFS_STATUS, 8'h00);
    send(w2, 1'b0, 1'b1);
    rd(SRSF_OFS_STATUS, 8'h08);
    wr(SRSF_OFS_STATUS, 8'h00);
    rd(SRSF_OFS_IRQ_ST, 8'h07);
    wr(SRSF_OFS_IRQ_EN, 8'h00);
    lvl(4'h0);
    wr(SRSF_OFS_IRQ_EN, 8'h02);
    lvl(4'h1);
    wr(SRSF_OFS_IRQ_CLR, 8'h07);
    rd(SRSF_OFS_IRQ_ST, 8'h00);
    lvl(4'h0);
    finish_test();
  end
endmodule : srsf_top_tb
